// *** core/dcc_consts.vh ***
// constants for the dual comparator control block
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// register word indices; every register is word aligned, so the bus
// byte address of each register is four times its index
`define DCC_IDX_CMP_ONE 8'hac
`define DCC_IDX_CMP_TWO 8'had
`define DCC_IDX_PORT0_DIS 8'hf6
`define DCC_IDX_INT_CTRL 8'hf0
`define DCC_IDX_PORT0_READ 8'hf1
`define DCC_IDX_STATUS 8'hf2
// control field positions
`define DCC_BIT_ENABLE 5
`define DCC_BIT_POS_SEL 4
`define DCC_BIT_NEG_SEL 3
`define DCC_BIT_PIN_OE 2
`define DCC_BIT_RESULT 1
`define DCC_BIT_FLAG 0
// interrupt control fields (own register)
`define DCC_BIT_GIE 2
`define DCC_BIT_IE_ONE 1
`define DCC_BIT_IE_TWO 0
// reset values
`define DCC_RST_CTRL 8'h00
`define DCC_RST_PORT0 8'h00
`define DCC_RST_INT 3'h0
// settling interval: 10 us at 4 ns period (longest time, rounded down)
`define DCC_SETTLE_NS 10000
`define DCC_CLK_NS 4
`define DCC_SETTLE_CYC (`DCC_SETTLE_NS / `DCC_CLK_NS)
// axi responses
`define DCC_RESP_OKAY 2'b00
`define DCC_RESP_SLVERR 2'b10
`endif

// *** core/dcc_sync2.v ***
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module dcc_sync2
(
    input wire aclk,
    input wire aresetn,
    input wire async_in,
    output wire sync_out
);
    reg meta_q; // first stage, read only by second stage
    reg sync_q; // second stage
    // ---------------------------------------------
    // capture chain
    // ---------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // dcc_sync2

// *** core/dcc_channel.v ***
// one comparator channel: control bits, synced result, change flag
`timescale 1ns/1ns
`include "dcc_consts.vh"
module dcc_channel
(
    input wire aclk,
    input wire aresetn,
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire result_sync,
    output wire [7:0] ctrl_rd,
    output reg flag_q,
    output reg synced_compare_result_q,
    output reg enable_q,
    output reg pos_sel_q,
    output reg neg_sel_q,
    output reg pin_oe_q,
    output reg settled_q
);
    reg [11:0] settle_cnt_q; // settling counter
    wire change;             // synced result toggled
    // software-visible byte; reserved bits read zero
    assign ctrl_rd = {2'b00, enable_q, pos_sel_q, neg_sel_q, pin_oe_q,
                      synced_compare_result_q, flag_q};
    // change gated by enable, so disable also zeroes it
    assign change = enable_q && (result_sync != synced_compare_result_q);
    // ---------------------------------------------
    // control bits, result and flag
    // ---------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_q <= 1'b0;
            pos_sel_q <= 1'b0;
            neg_sel_q <= 1'b0;
            pin_oe_q <= 1'b0;
            synced_compare_result_q <= 1'b0;
            flag_q <= 1'b0;
            settle_cnt_q <= 12'h000;
            settled_q <= 1'b0;
        end
        else
        begin
            if (wr_en)
            begin
                enable_q <= wr_data[`DCC_BIT_ENABLE];
                pos_sel_q <= wr_data[`DCC_BIT_POS_SEL];
                neg_sel_q <= wr_data[`DCC_BIT_NEG_SEL];
                pin_oe_q <= wr_data[`DCC_BIT_PIN_OE];
            end
            // result only tracks while enabled, else reads zero
            if (enable_q)
                synced_compare_result_q <= result_sync;
            else
                synced_compare_result_q <= 1'b0;
            // hardware set beats software clear
            if (!enable_q)
                flag_q <= 1'b0;
            else if (change)
                flag_q <= 1'b1;
            else if (wr_en && !wr_data[`DCC_BIT_FLAG])
                flag_q <= 1'b0;
            // settling tracker, status only; values may be unsettled
            if (!enable_q)
            begin
                settle_cnt_q <= 12'h000;
                settled_q <= 1'b0;
            end
            else if (settle_cnt_q == `DCC_SETTLE_CYC - 1)
                settled_q <= 1'b1;
            else
                settle_cnt_q <= settle_cnt_q + 12'h001;
        end
    end
endmodule // dcc_channel

// *** core/dcc_top.v ***
// dual comparator control: axi4-lite registers, routing, irq
// Overview of operation
// - two 8-bit control registers, reset zero
// - result high when positive exceeds negative
// - bit 5 enables the comparator
// - outputs may be unsettled for 10 us
// - select bits set four input configurations
// - bit 4 positive pin, bit 3 negative source
// - bit 2 drives synced result to pin
// - bit 1 synced result, zero when disabled
// - any synced result change sets flag
// - set flag requests comparator interrupt
// - flag cleared by zero write or disable
// - irq needs per-comparator and global enable
// - comparators run and wake in low power
// - port 0 digital input disable register
// - disabled port bits read as zero
`timescale 1ns/1ns
`include "dcc_consts.vh"
module dcc_top
(
    input wire aclk,
    input wire aresetn,
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmp_one_result,
    input wire cmp_two_result,
    input wire [7:0] port0_pins,
    output reg cmp_one_pin,
    output reg cmp_two_pin,
    output reg cmp_one_pos_sel,
    output reg cmp_one_neg_sel,
    output reg cmp_two_pos_sel,
    output reg cmp_two_neg_sel,
    output reg cmp_one_power,
    output reg cmp_two_power,
    output reg [7:0] port0_digital_input_disable,
    output reg comparator_irq,
    output reg wake_request
);
    // -------------------------------------------------
    // write channel state
    // -------------------------------------------------
    reg aw_held_q;         // write address captured
    reg w_held_q;          // write data captured
    reg [7:0] aw_addr_q;   // captured register index
    reg [31:0] w_data_q;   // captured write data
    reg [3:0] w_strb_q;    // captured strobes
    reg [2:0] int_ctrl_q;  // gie, ie one, ie two
    wire do_write;         // both halves present, response free
    wire wr_lane0;         // low byte lane written
    wire wr_one;           // control one write
    wire wr_two;           // control two write
    // channel outputs
    wire [7:0] one_rd;     // control one readback
    wire [7:0] two_rd;     // control two readback
    wire one_flag;
    wire two_flag;
    wire one_res;
    wire two_res;
    wire one_en;
    wire two_en;
    wire one_ps;
    wire two_ps;
    wire one_ns;
    wire two_ns;
    wire one_oe;
    wire two_oe;
    wire one_set;
    wire two_set;
    // synchronised analog results and port pins
    wire one_sync;
    wire two_sync;
    wire [7:0] port0_sync;
    wire irq_d;            // gated interrupt request
    reg [31:0] rd_d;       // read mux
    reg rd_ok_d;           // mapped read address
    // strobes: only lane 0 carries the 8-bit registers
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb_q[0];
    assign wr_one = wr_lane0 && (aw_addr_q == `DCC_IDX_CMP_ONE);
    assign wr_two = wr_lane0 && (aw_addr_q == `DCC_IDX_CMP_TWO);
    // -------------------------------------------------
    // input synchronisers
    // -------------------------------------------------
    // comparator result arrives asynchronously
    dcc_sync2 u_sync_one
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(cmp_one_result),
        .sync_out(one_sync)
    );
    dcc_sync2 u_sync_two
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(cmp_two_result),
        .sync_out(two_sync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_port
            dcc_sync2 u_sync_p
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .async_in(port0_pins[gi]),
                .sync_out(port0_sync[gi])
            );
        end
    endgenerate
    // -------------------------------------------------
    // comparator channels
    // -------------------------------------------------
    dcc_channel u_one
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_one),
        .wr_data(w_data_q[7:0]),
        .result_sync(one_sync),
        .ctrl_rd(one_rd),
        .flag_q(one_flag),
        .synced_compare_result_q(one_res),
        .enable_q(one_en),
        .pos_sel_q(one_ps),
        .neg_sel_q(one_ns),
        .pin_oe_q(one_oe),
        .settled_q(one_set)
    );
    dcc_channel u_two
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_two),
        .wr_data(w_data_q[7:0]),
        .result_sync(two_sync),
        .ctrl_rd(two_rd),
        .flag_q(two_flag),
        .synced_compare_result_q(two_res),
        .enable_q(two_en),
        .pos_sel_q(two_ps),
        .neg_sel_q(two_ns),
        .pin_oe_q(two_oe),
        .settled_q(two_set)
    );
    // request needs a flag, its enable and the global enable
    assign irq_d = int_ctrl_q[`DCC_BIT_GIE] &&
        ((one_flag && int_ctrl_q[`DCC_BIT_IE_ONE]) ||
         (two_flag && int_ctrl_q[`DCC_BIT_IE_TWO]));
    // -------------------------------------------------
    // routing and interrupt outputs
    // -------------------------------------------------
    // the pin path registers the two-flop synchronised result once
    // more, three flops in all; the channel uses the same synced copy
    // and no clock enable gates it
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_one_pin <= 1'b0;
            cmp_two_pin <= 1'b0;
            cmp_one_pos_sel <= 1'b0;
            cmp_one_neg_sel <= 1'b0;
            cmp_two_pos_sel <= 1'b0;
            cmp_two_neg_sel <= 1'b0;
            cmp_one_power <= 1'b0;
            cmp_two_power <= 1'b0;
            comparator_irq <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            cmp_one_pin <= one_en && one_oe && one_sync;
            cmp_two_pin <= two_en && two_oe && two_sync;
            cmp_one_pos_sel <= one_ps;
            cmp_one_neg_sel <= one_ns;
            cmp_two_pos_sel <= two_ps;
            cmp_two_neg_sel <= two_ns;
            cmp_one_power <= one_en;
            cmp_two_power <= two_en;
            comparator_irq <= irq_d;
            // wake has no clock gating here; any low-power mode keeps
            // comparators running and a flagged change wakes the core when its
            // comparator enable and the global enable are set
            wake_request <= irq_d;
        end
    end
    // -------------------------------------------------
    // read mux
    // -------------------------------------------------
    always @*
    begin
        rd_d = 32'h0000_0000;
        rd_ok_d = 1'b1;
        // word index only; the two low byte-address bits are ignored
        case (s_axi_araddr[9:2])
            `DCC_IDX_CMP_ONE: rd_d = {24'h00_0000, one_rd};
            `DCC_IDX_CMP_TWO: rd_d = {24'h00_0000, two_rd};
            `DCC_IDX_PORT0_DIS:
                rd_d = {24'h00_0000, port0_digital_input_disable};
            `DCC_IDX_INT_CTRL: rd_d = {29'h0000_0000, int_ctrl_q};
            // disabled pins read zero whatever the level
            `DCC_IDX_PORT0_READ:
                rd_d = {24'h00_0000,
                        port0_sync & ~port0_digital_input_disable};
            `DCC_IDX_STATUS: rd_d = {30'h0000_0000, two_set, one_set};
            default: rd_ok_d = 1'b0;
        endcase
    end
    // -------------------------------------------------
    // axi write path
    // -------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCC_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            port0_digital_input_disable <= `DCC_RST_PORT0;
            int_ctrl_q <= `DCC_RST_INT;
        end
        else
        begin
            // ready pulses for one cycle when each half is taken
            s_axi_awready <= !aw_held_q && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_held_q && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[9:2]; // word index
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `DCC_IDX_CMP_ONE, `DCC_IDX_CMP_TWO:
                        s_axi_bresp <= `DCC_RESP_OKAY;
                    `DCC_IDX_PORT0_DIS:
                    begin
                        s_axi_bresp <= `DCC_RESP_OKAY;
                        if (w_strb_q[0])
                            port0_digital_input_disable <=
                                w_data_q[7:0];
                    end
                    `DCC_IDX_INT_CTRL:
                    begin
                        s_axi_bresp <= `DCC_RESP_OKAY;
                        if (w_strb_q[0])
                            int_ctrl_q <= w_data_q[2:0];
                    end
                    `DCC_IDX_PORT0_READ, `DCC_IDX_STATUS:
                        s_axi_bresp <= `DCC_RESP_OKAY;
                    default:
                        s_axi_bresp <= `DCC_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    // -------------------------------------------------
    // axi read path
    // -------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DCC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok_d ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // dcc_top

// *** tb/dcc_analog_model.sv ***
// behavioural model of one analog comparator and its input pins
`timescale 1ns/1ns
module dcc_analog_model
#(
    parameter int VREF_MV = 1230 // internal reference in millivolts
)
(
    input logic aclk,
    input logic power,
    input logic pos_sel,
    input logic neg_sel,
    input int pin_a_mv, // first positive pin level
    input int pin_b_mv, // second positive pin level
    input int ref_mv, // negative reference pin level
    output logic result
);
    // --------------------------------
    // decision
    // --------------------------------
    initial result = 1'b0;
    // unpowered it wanders every cycle, so nothing may lean on it
    always @(posedge aclk)
        if (!power)
            result <= ~result;
        else
            result <= (pos_sel ? pin_b_mv : pin_a_mv) >
                (neg_sel ? VREF_MV : ref_mv);
endmodule // dcc_analog_model

// *** tb/dcc_properties.sv ***
// port assertions for the dual comparator control block
`timescale 1ns/1ns
module dcc_properties
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmp_one_pin,
    input wire cmp_two_pin,
    input wire cmp_one_power,
    input wire cmp_two_power,
    input wire [7:0] port0_digital_input_disable,
    input wire comparator_irq,
    input wire wake_request
);
    // --------------------------------
    // helpers
    // --------------------------------
    wire w_take; // write data accepted this cycle
    assign w_take = s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------------------------------
    // properties
    // --------------------------------
    a_pin_one_off:
    assert property (!cmp_one_power && !$past(cmp_one_power) |-> !cmp_one_pin)
        else $error("pin one driven while disabled");
    a_pin_two_off:
    assert property (!cmp_two_power && !$past(cmp_two_power) |-> !cmp_two_pin)
        else $error("pin two driven while disabled");
    a_wake_matches_irq:
    assert property (comparator_irq == wake_request)
        else $error("wake request differs from irq");
    a_bresp_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answered:
    assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
        else $error("write not answered");
    a_read_answered:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_port0_by_write:
    assert property ($changed(port0_digital_input_disable) |->
        $past(w_take, 1) || $past(w_take, 2) || $past(w_take, 3))
        else $error("port0 disable changed without write");
endmodule // dcc_properties

bind dcc_top dcc_properties dcc_properties_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .cmp_one_pin, .cmp_two_pin, .cmp_one_power, .cmp_two_power,
    .port0_digital_input_disable, .comparator_irq, .wake_request);

// *** tb/tb_dual_comparator_control.sv ***
// self-checking bench for the dual comparator control block
`timescale 1ns/1ns
`include "dcc_consts.vh"
module tb_dual_comparator_control;
    // --------------------------------
    // signals
    // --------------------------------
    logic aclk = 0, aresetn = 0;
    logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0; // byte addresses
    logic [7:0] port0_pins = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cmp_one_result, cmp_two_result;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cmp_one_pin, cmp_two_pin, cmp_one_pos_sel, cmp_one_neg_sel;
    logic cmp_two_pos_sel, cmp_two_neg_sel, cmp_one_power, cmp_two_power;
    logic [7:0] port0_digital_input_disable;
    logic comparator_irq, wake_request;
    int mv_a = 0, mv_b = 0, mv_ref = 0; // analog pin levels
    int miscompares = 0, compares = 0, cycles = 0;
    // short names for register indices and responses
    localparam logic [7:0] C1 = `DCC_IDX_CMP_ONE;
    localparam logic [7:0] C2 = `DCC_IDX_CMP_TWO;
    localparam logic [7:0] PD = `DCC_IDX_PORT0_DIS;
    localparam logic [7:0] IC = `DCC_IDX_INT_CTRL;
    localparam logic [7:0] PR = `DCC_IDX_PORT0_READ;
    localparam logic [7:0] ST = `DCC_IDX_STATUS;
    localparam logic [1:0] OK = `DCC_RESP_OKAY;
    localparam logic [1:0] ER = `DCC_RESP_SLVERR;
    dcc_top dcc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_one_result,
        .cmp_two_result, .port0_pins, .cmp_one_pin, .cmp_two_pin,
        .cmp_one_pos_sel, .cmp_one_neg_sel, .cmp_two_pos_sel,
        .cmp_two_neg_sel, .cmp_one_power, .cmp_two_power,
        .port0_digital_input_disable, .comparator_irq, .wake_request);
    dcc_analog_model one_i (.aclk, .power(cmp_one_power),
        .pos_sel(cmp_one_pos_sel), .neg_sel(cmp_one_neg_sel),
        .pin_a_mv(mv_a), .pin_b_mv(mv_b), .ref_mv(mv_ref),
        .result(cmp_one_result));
    dcc_analog_model two_i (.aclk, .power(cmp_two_power),
        .pos_sel(cmp_two_pos_sel), .neg_sel(cmp_two_neg_sel),
        .pin_a_mv(mv_a), .pin_b_mv(mv_b), .ref_mv(mv_ref),
        .result(cmp_two_result));
    initial forever #2 aclk = ~aclk;
    // hang guard: the run needs about three thousand cycles, most of
    // them spent waiting out the settling interval
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end
    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // offers address and data together, releases each when taken;
    // waits as long as the slave needs, only the hang guard ends it
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er);
        bit aw_ok, w_ok, got;
        aw_ok = 0;
        w_ok = 0;
        got = 0;
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'b00}; // index to byte address
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid)
            begin
                got = 1;
                check(s_axi_bresp, er, "write response");
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed,
        input logic [1:0] er, input string m);
        bit got;
        got = 0;
        @(posedge aclk);
        s_axi_araddr <= {a, 2'b00}; // index to byte address
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                got = 1;
                check(s_axi_rdata, {24'h0, ed}, m);
                check(s_axi_rresp, er, m);
            end
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_reset();
        rd(C1, 8'h00, OK, "ctrl one reset");
        rd(C2, 8'h00, OK, "ctrl two reset");
        rd(PD, 8'h00, OK, "port0 reset");
        rd(8'h10, 8'h00, ER, "unmapped read");
        wr(8'h10, 8'hff, ER);
        $display("test reset done");
    endtask
    task automatic t_flag();
        mv_a <= 2000;
        mv_ref <= 1000;
        wr(C1, 8'h24, OK);
        settle(12);
        check(cmp_one_pin, 1'b1, "pin one follows result");
        rd(C1, 8'h27, OK, "rise sets flag");
        wr(C1, 8'h24, OK);
        rd(C1, 8'h26, OK, "flag cleared");
        mv_a <= 500;
        settle(12);
        rd(C1, 8'h25, OK, "fall sets flag");
        wr(C1, 8'h04, OK);
        mv_a <= 2000;
        settle(12);
        rd(C1, 8'h04, OK, "disabled reads 0");
        check(cmp_one_power, 1'b0, "power off");
        $display("test flag done");
    endtask
    // software waits out settling and clears the flag before it
    // enables the interrupt, so only a real change may raise it
    task automatic t_irq();
        wr(C1, 8'h20, OK);
        settle(`DCC_SETTLE_CYC);
        rd(ST, 8'h01, OK, "one settled");
        wr(C1, 8'h20, OK);
        wr(IC, 8'h06, OK);
        settle(3);
        check(comparator_irq, 1'b0, "no change no irq");
        mv_a <= 500;
        settle(12);
        check(comparator_irq, 1'b1, "change gives irq");
        check(wake_request, 1'b1, "change gives wake");
        wr(IC, 8'h02, OK);
        settle(3);
        check(comparator_irq, 1'b0, "irq without global");
        wr(IC, 8'h06, OK);
        settle(3);
        check(comparator_irq, 1'b1, "irq with global");
        wr(C1, 8'h20, OK);
        settle(3);
        check(comparator_irq, 1'b0, "cleared flag drops irq");
        wr(IC, 8'h00, OK);
        $display("test irq done");
    endtask
    task automatic t_route();
        logic exp;
        mv_a <= 2000;
        mv_b <= 500;
        mv_ref <= 1400;
        // all eight settings of positive, negative and pin enable;
        // the reserved upper bits are always written as zero
        for (int i = 0; i < 8; i++)
        begin
            wr(C1, {3'b001, i[2:0], 2'b00}, OK);
            exp = (i[2] ? mv_b : mv_a) > (i[1] ? 1230 : mv_ref);
            settle(12);
            check(cmp_one_pos_sel, i[2], "pos select");
            check(cmp_one_neg_sel, i[1], "neg select");
            check(cmp_one_pin, i[0] & exp, "pin routing");
        end
        wr(C2, 8'h34, OK);
        mv_b <= 2000;
        settle(12);
        check(cmp_two_power, 1'b1, "two power");
        check(cmp_two_pos_sel, 1'b1, "two pos select");
        check(cmp_two_neg_sel, 1'b0, "two neg select");
        check(cmp_two_pin, 1'b1, "two pin");
        rd(C2, 8'h37, OK, "two result");
        wr(IC, 8'h05, OK);
        settle(3);
        check(comparator_irq, 1'b1, "two flag gives irq");
        wr(IC, 8'h00, OK);
        $display("test route done");
    endtask
    task automatic t_port0();
        port0_pins <= 8'hff;
        wr(PD, 8'h30, OK);
        settle(4);
        check(port0_digital_input_disable, 8'h30, "disable out");
        rd(PD, 8'h30, OK, "disable back");
        rd(PR, 8'hcf, OK, "port read");
        $display("test port0 done");
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_flag();
        t_irq();
        t_route();
        t_port0();
        complete_run();
    end
endmodule // tb_dual_comparator_control
